// [common/qsr_pkg.sv]
package qsr_pkg;
    // ------------------------------------------------------------
    // Widths and depths
    // ------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int CMD_W = 8;
    localparam int OUT_W = 32;
    localparam int SR_W = 128;
    localparam int LEN_W = 7;
    localparam int CNT_W = 12;
    localparam int DIV_W = 8;
    localparam int PER_W = 9;
    localparam int DUM_W = 4;
    localparam int BUF_DEPTH = 2;
    localparam int AGE_W = 16;
    // ------------------------------------------------------------
    // Encodings of width and pin modes
    // ------------------------------------------------------------
    localparam logic [1:0] WID_SINGLE = 2'h0;
    localparam logic [1:0] WID_DUAL = 2'h1;
    localparam logic [1:0] WID_QUAD = 2'h2;
    localparam logic [1:0] PINS_3 = 2'h0;
    localparam logic [1:0] PINS_4 = 2'h1;
    localparam logic [1:0] PINS_6 = 2'h2;
    // ------------------------------------------------------------
    // Counts and reset values
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] OUT_LAST = 12'h01f;
    localparam logic [CNT_W-1:0] TAIL_LAST = 12'h001;
    localparam logic [LEN_W-1:0] LEN_MAX = 7'h7f;
    localparam logic [PER_W-1:0] DIV0_PERIOD = 9'h002;
    localparam logic [PER_W-1:0] DIV0_HIGH = 9'h001;
    localparam logic [3:0] OE_N_CMD = 4'he;
    localparam logic [3:0] OE_N_IDLE = 4'hf;
    localparam logic [SR_W-1:0] SR_RST = 128'h0;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_LEAD = 6'h02,
        ST_SHIFT = 6'h04,
        ST_DUMMY = 6'h08,
        ST_DATA = 6'h10,
        ST_TAIL = 6'h20
    } qsr_state_e;

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic [1:0] cs_dly;
        logic [LEN_W-1:0] word_len;
        logic [CNT_W-1:0] word_cnt;
        logic [1:0] pins;
        logic [CMD_W-1:0] opcode;
        logic [DUM_W-1:0] dummy;
        logic word_irq_en;
        logic frame_irq_en;
    } qsr_cfg_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [1:0] width;
    } qsr_req_s;

    function automatic logic [2:0] qsr_lanes(input logic [1:0] width, input logic [1:0] pins);
        if (pins != PINS_6) begin
            return 3'h1;
        end
        case (width)
            WID_DUAL: return 3'h2;
            WID_QUAD: return 3'h4;
            default: return 3'h1;
        endcase
    endfunction
endpackage

// [core/qsr_buf.sv]
`timescale 1ns/1ps
`default_nettype none
module qsr_buf
    import qsr_pkg::*;
#(
    parameter int W = SR_W
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [1:0] level
);
    // ------------------------------------------------------------
    // Two slots, slot 0 is the head
    // ------------------------------------------------------------
    // Head sits in a flop so the read port needs no mux
    logic [W-1:0] mem [0:BUF_DEPTH-1];
    logic [BUF_DEPTH-1:0] vld_reg;
    logic [W-1:0] up_w [0:BUF_DEPTH-1];
    logic push_w;
    logic pop_w;
    logic [1:0] lvl_after_w;
    logic [1:0] widx_w;

    assign level = {1'b0, vld_reg[0]} + {1'b0, vld_reg[1]};
    assign in_ready = !vld_reg[BUF_DEPTH-1];
    assign out_valid = vld_reg[0];
    assign out_data = mem[0];
    assign push_w = in_valid && in_ready;
    assign pop_w = out_valid && out_ready;
    assign lvl_after_w = level + {1'b0, push_w} - {1'b0, pop_w};
    assign widx_w = level - {1'b0, pop_w};

    for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_slot
        if (i == BUF_DEPTH - 1) begin : g_last
            assign up_w[i] = in_data;
        end else begin : g_mid
            assign up_w[i] = mem[i+1];
        end
        always_ff @(posedge clk) begin
            if (!rstn) begin
                mem[i] <= SR_RST;
                vld_reg[i] <= 1'b0;
            end else if (ce) begin
                if (push_w && widx_w == 2'(i)) begin
                    mem[i] <= in_data;
                end else if (pop_w) begin
                    mem[i] <= up_w[i];
                end
                vld_reg[i] <= (lvl_after_w > 2'(i));
            end
        end
    end
endmodule
`default_nettype wire

// [core/qsr_clkdiv.sv]
`timescale 1ns/1ps
`default_nettype none
module qsr_clkdiv
    import qsr_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic run,
    input wire logic [DIV_W-1:0] div,
    output logic rise_tick,
    output logic fall_tick,
    output logic [PER_W-1:0] period,
    output logic [PER_W-1:0] high
);
    // ------------------------------------------------------------
    // Period and high time
    // ------------------------------------------------------------
    // Zero cannot give one system cycle per period, so it runs as two
    logic [PER_W-1:0] cnt_reg;
    logic [PER_W-1:0] cnt_next;

    assign period = (div == 8'h00) ? DIV0_PERIOD : {1'b0, div} + 9'h001; // R10
    assign high = (div == 8'h00) ? DIV0_HIGH : (period >> 1); // R10
    assign rise_tick = run && (cnt_reg == period - high - 9'h001);
    assign fall_tick = run && (cnt_reg == period - 9'h001);
    assign cnt_next = (!run || fall_tick) ? 9'h000 : cnt_reg + 9'h001;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_reg <= 9'h000;
        end else if (ce) begin
            cnt_reg <= cnt_next;
        end
    end
endmodule
`default_nettype wire

// [core/qsr_core.sv]
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [R01] Master only: drives serial clock and chip select, never answers as target
// [R02] Reads over one, two or four data lines, chosen per request
// [R03] Word length programmable from 1 to 128 bits
// [R04] Words per frame programmable from 1 to 4096
// [R05] Three, four or six wire hookup; six wires carry four data lines
// [R06] Optional event pulse per finished word or per finished frame
// [R07] Select-to-data delay programmable from 0 to 3 serial periods
// [R08] Serial clock idles low, phase zero, mode 0
// [R09] Input bits are taken at falling serial clock edges
// [R10] Divider: zero or odd gives even duty, even gives high fraction d/2/(d+1)
// [R11] Select goes active delay+1 periods before the first falling edge
// [R12] Select goes inactive two periods after the last falling edge
// [R13] A read request becomes a serial read; data returns as plain words
// [R14] Flash presents each bit before the sampling fall while selected
module qsr_core
    import qsr_pkg::*;
(
    // Clock, reset, enable
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CE,
    // Configuration
    input wire qsr_cfg_s CFG,
    // Read request
    input wire logic REQ_VALID,
    input wire qsr_req_s REQ,
    output logic REQ_READY,
    output logic BUSY,
    // Read data
    output logic [SR_W-1:0] RD_DATA,
    output logic RD_VALID,
    input wire logic RD_READY,
    // Events
    output logic IRQ_WORD,
    output logic IRQ_FRAME,
    // Serial pins
    output logic SCLK,
    output logic CS_N,
    output logic [3:0] D_OUT,
    output logic [3:0] D_OE_N,
    input wire logic [3:0] D_IN
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    qsr_state_e st_reg;
    qsr_state_e st_next;
    qsr_cfg_s cfg_reg;
    logic [2:0] lanes_reg;
    logic idle_reg;
    logic run_reg;
    logic sclk_reg;
    logic clk_on_reg;
    logic clk_on_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] word_reg;
    logic [7:0] bit_reg;
    logic [OUT_W-1:0] osr_reg;
    logic [SR_W-1:0] isr_reg;
    logic [3:0] oe_n_reg;
    logic irq_w_reg;
    logic irq_f_reg;
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic rise_w;
    logic fall_w;
    logic [PER_W-1:0] period_w;
    logic [PER_W-1:0] high_w;
    logic buf_ready_w;
    logic buf_valid_w;
    logic [1:0] buf_lvl_w;
    logic [1:0] fill_w;
    logic accept_w;
    logic samp_w;
    logic [7:0] bit_sum_w;
    logic word_end_w;
    logic frame_end_w;
    logic din1_w;
    logic space_ok_w;
    logic [CNT_W-1:0] lim_w;
    logic cnt_last_w;
    logic [SR_W-1:0] isr_next;
    logic [SR_W-1:0] mask_w;

    assign accept_w = REQ_VALID && idle_reg; // R13
    assign samp_w = fall_w && clk_on_reg && (st_reg == ST_DATA); // R09 R14
    assign bit_sum_w = bit_reg + {5'h00, lanes_reg};
    assign word_end_w = samp_w && (bit_sum_w >= {1'b0, cfg_reg.word_len} + 8'h01); // R03
    assign frame_end_w = word_end_w && (word_reg == cfg_reg.word_cnt); // R04
    // Three-wire hookup shares one line for both directions
    assign din1_w = (cfg_reg.pins == PINS_3) ? D_IN[0] : D_IN[1]; // R05
    assign isr_next = (lanes_reg == 3'h4) ? {isr_reg[SR_W-5:0], D_IN} :
                      (lanes_reg == 3'h2) ? {isr_reg[SR_W-3:0], D_IN[1:0]} :
                      {isr_reg[SR_W-2:0], din1_w}; // R02
    assign mask_w = {SR_W{1'b1}} >> (LEN_MAX - cfg_reg.word_len); // R03
    // Room must count the word landing now, or a stall would drop one
    assign fill_w = buf_lvl_w + {1'b0, word_end_w} - {1'b0, buf_valid_w && RD_READY};
    assign space_ok_w = buf_ready_w && (fill_w < 2'h2);
    assign lim_w = (st_reg == ST_LEAD) ? {10'h000, cfg_reg.cs_dly} - 12'h001 :
                   (st_reg == ST_SHIFT) ? OUT_LAST :
                   (st_reg == ST_DUMMY) ? {8'h00, cfg_reg.dummy} - 12'h001 : TAIL_LAST;
    assign cnt_last_w = (cnt_reg == lim_w);

    qsr_clkdiv u_div (
        .clk(CLK),
        .rstn(RSTN),
        .ce(CE),
        .run(run_reg),
        .div(cfg_reg.div),
        .rise_tick(rise_w),
        .fall_tick(fall_w),
        .period(period_w),
        .high(high_w)
    );

    qsr_buf #(.W(SR_W)) u_buf (
        .clk(CLK),
        .rstn(RSTN),
        .ce(CE),
        .in_valid(word_end_w),
        .in_ready(buf_ready_w),
        .in_data(isr_next & mask_w),
        .out_valid(buf_valid_w),
        .out_ready(RD_READY),
        .out_data(RD_DATA),
        .level(buf_lvl_w)
    );
    assign RD_VALID = buf_valid_w;

    // ------------------------------------------------------------
    // Sequencer, stepped once per serial period
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        clk_on_next = clk_on_reg;
        if (fall_w) begin
            cnt_next = cnt_last_w ? 12'h000 : cnt_reg + 12'h001;
        end
        case (st_reg)
            ST_IDLE: begin
                cnt_next = 12'h000;
                if (accept_w) begin
                    st_next = (CFG.cs_dly == 2'h0) ? ST_SHIFT : ST_LEAD; // R07 R11
                    clk_on_next = (CFG.cs_dly == 2'h0);
                end
            end
            ST_LEAD: begin
                if (fall_w && cnt_last_w) begin
                    st_next = ST_SHIFT; // R11
                    clk_on_next = 1'b1;
                end
            end
            ST_SHIFT: begin
                if (fall_w && cnt_last_w) begin
                    st_next = (cfg_reg.dummy == 4'h0) ? ST_DATA : ST_DUMMY;
                    clk_on_next = (cfg_reg.dummy == 4'h0) ? space_ok_w : 1'b1;
                end
            end
            ST_DUMMY: begin
                if (fall_w && cnt_last_w) begin
                    st_next = ST_DATA;
                    clk_on_next = space_ok_w;
                end
            end
            ST_DATA: begin
                cnt_next = 12'h000;
                if (fall_w) begin
                    st_next = frame_end_w ? ST_TAIL : ST_DATA; // R04
                    clk_on_next = !frame_end_w && space_ok_w;
                end
            end
            ST_TAIL: begin
                clk_on_next = 1'b0;
                if (fall_w && cnt_last_w) begin
                    st_next = ST_IDLE; // R12
                end
            end
            default: begin
                st_next = ST_IDLE;
                clk_on_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            st_reg <= ST_IDLE;
            cnt_reg <= 12'h000;
            clk_on_reg <= 1'b0;
            idle_reg <= 1'b1;
            run_reg <= 1'b0;
        end else if (CE) begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            clk_on_reg <= clk_on_next;
            idle_reg <= (st_next == ST_IDLE); // R01 R12
            run_reg <= (st_next != ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Serial clock, command shifter, pin enables
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            sclk_reg <= 1'b0;
        end else if (CE) begin
            if (fall_w) begin
                sclk_reg <= 1'b0; // R08
            end else if (rise_w && clk_on_reg) begin
                sclk_reg <= 1'b1; // R01 R10
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            osr_reg <= 32'h0000_0000;
            oe_n_reg <= OE_N_IDLE;
        end else if (CE) begin
            if (accept_w) begin
                osr_reg <= {CFG.opcode, REQ.addr}; // R13
                oe_n_reg <= OE_N_CMD;
            end else if (fall_w && st_reg == ST_SHIFT) begin
                osr_reg <= {osr_reg[OUT_W-2:0], 1'b0};
                oe_n_reg <= cnt_last_w ? OE_N_IDLE : OE_N_CMD;
            end
        end
    end

    // ------------------------------------------------------------
    // Word capture and events
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            cfg_reg <= '0;
            lanes_reg <= 3'h1;
            bit_reg <= 8'h00;
            word_reg <= 12'h000;
            isr_reg <= SR_RST;
        end else if (CE) begin
            if (accept_w) begin
                cfg_reg <= CFG;
                lanes_reg <= qsr_lanes(REQ.width, CFG.pins); // R02 R05
                bit_reg <= 8'h00;
                word_reg <= 12'h000;
            end else if (samp_w) begin
                isr_reg <= isr_next; // R09
                bit_reg <= word_end_w ? 8'h00 : bit_sum_w;
                word_reg <= word_end_w ? word_reg + 12'h001 : word_reg;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            irq_w_reg <= 1'b0;
            irq_f_reg <= 1'b0;
        end else if (CE) begin
            irq_w_reg <= word_end_w && cfg_reg.word_irq_en; // R06
            irq_f_reg <= frame_end_w && cfg_reg.frame_irq_en; // R06
        end
    end

    assign REQ_READY = idle_reg;
    assign CS_N = idle_reg;
    assign BUSY = run_reg;
    assign SCLK = sclk_reg;
    assign D_OUT = {3'h0, osr_reg[OUT_W-1]};
    assign D_OE_N = oe_n_reg;
    assign IRQ_WORD = irq_w_reg;
    assign IRQ_FRAME = irq_f_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic sclk_q_reg;
    logic seen_reg;
    logic [AGE_W-1:0] hi_cnt_reg;
    logic [AGE_W-1:0] cs_age_reg;
    logic [AGE_W-1:0] since_reg;
    logic fell_w;

    assign fell_w = sclk_q_reg && !SCLK;

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            sclk_q_reg <= 1'b0;
            seen_reg <= 1'b0;
            hi_cnt_reg <= 16'h0000;
            cs_age_reg <= 16'h0000;
            since_reg <= 16'h0000;
        end else if (CE) begin
            sclk_q_reg <= SCLK;
            seen_reg <= !CS_N && (seen_reg || fell_w);
            hi_cnt_reg <= SCLK ? hi_cnt_reg + 16'h0001 : 16'h0000;
            cs_age_reg <= CS_N ? 16'h0000 : cs_age_reg + 16'h0001;
            since_reg <= fell_w ? 16'h0001 : since_reg + 16'h0001;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN || !CE);

    a_cs_from_req: assert property ($fell(CS_N) |-> $past(REQ_VALID) && BUSY) // R01
        else $error("select went active without a request");
    a_map_read: assert property (accept_w |=> !CS_N && !REQ_READY ##0 !D_OE_N[0]) // R13
        else $error("accepted request did not start a serial read");
    a_sclk_idle: assert property (CS_N |-> !SCLK) // R08
        else $error("serial clock not low while idle");
    a_sample_fall: assert property (samp_w |-> SCLK ##1 !SCLK) // R09
        else $error("input sampled away from a falling edge");
    a_lane_legal: assert property (st_reg == ST_DATA |->
        lanes_reg == qsr_lanes(WID_QUAD, cfg_reg.pins) || lanes_reg <= 3'h2) // R02
        else $error("illegal lane count");
    a_pin_mode: assert property (st_reg == ST_DATA && cfg_reg.pins != PINS_6 |->
        lanes_reg == 3'h1) // R05
        else $error("multi-lane read without six wires");
    a_word_len: assert property (word_end_w |->
        int'(bit_reg) < int'(cfg_reg.word_len) + 1) // R03
        else $error("word ended late");
    a_frame_end: assert property (frame_end_w |=> st_reg == ST_TAIL && // R04
        word_reg == cfg_reg.word_cnt + 12'h001 ##1 !IRQ_FRAME)
        else $error("frame did not end on the word count");
    a_irq_word: assert property (word_end_w && cfg_reg.word_irq_en |=> IRQ_WORD ##1 !IRQ_WORD) // R06
        else $error("word event not a single pulse");
    a_duty_div: assert property (fell_w |-> hi_cnt_reg == AGE_W'(high_w)) // R10
        else $error("serial clock high time off");
    a_cs_lead: assert property (fell_w && !seen_reg |->
        int'(cs_age_reg) == (int'(cfg_reg.cs_dly) + 1) * int'(period_w)) // R07 R11
        else $error("select lead time off");
    a_cs_tail: assert property ($rose(CS_N) |-> int'(since_reg) == 2 * int'(period_w)) // R12
        else $error("select trail time off");
    a_buf_hold: assert property (RD_VALID && !RD_READY |=> RD_VALID && $stable(RD_DATA))
        else $error("read word changed while stalled");

    c_quad_frame: cover property (frame_end_w && lanes_reg == 3'h4);
    c_stall: cover property (st_reg == ST_DATA && fall_w && !clk_on_reg);
    c_long_lead: cover property (accept_w && CFG.cs_dly == 2'h3);
    c_full_word: cover property (word_end_w && cfg_reg.word_len == LEN_MAX);
endmodule
`default_nettype wire

// [verif/qsr_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
module qsr_flash_model
    import qsr_pkg::*;
(
    // Serial side
    input wire logic clk,
    input wire logic sclk,
    input wire logic cs_n,
    // Setup
    input wire logic [DUM_W-1:0] dummy,
    // Data toward master
    output logic [3:0] d_in
);
    // ------------------------------------------------------------
    // Fall counting
    // ------------------------------------------------------------
    logic sclk_reg = 1'b0;
    logic [3:0] junk_reg = 4'h5;
    int falls_reg = 0;
    int n;

    function automatic logic [3:0] pat(input int k);
        return 4'(k * 7 + 3);
    endfunction

    always @(posedge clk) begin
        sclk_reg <= sclk;
        junk_reg <= ~junk_reg;
        falls_reg <= cs_n ? 0 : n;
    end

    // Launch right after each fall, so the old slice holds through the sampling edge
    always_comb begin
        n = falls_reg + int'(sclk_reg & ~sclk);
        d_in = junk_reg;
        if (!cs_n && n >= 32 + int'(dummy)) begin
            d_in = pat(n - 32 - int'(dummy));
        end
    end
endmodule
`default_nettype wire

// [verif/quad_spi_read_master_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module quad_spi_read_master_tb_top
    import qsr_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic req_valid = 1'b0;
    logic rd_ready = 1'b0;
    qsr_cfg_s cfg = '0;
    qsr_req_s req = '0;
    logic req_ready, busy, rd_valid, irq_word, irq_frame, sclk, cs_n;
    logic [SR_W-1:0] rd_data;
    logic [3:0] d_out, d_oe_n, d_in;
    int fails = 0;
    int n_tests = 0;

    always #50 clk = ~clk;

    qsr_core u_qsr_core (.CLK(clk), .RSTN(rstn), .CE(1'b1), .CFG(cfg), .REQ_VALID(req_valid),
        .REQ(req), .REQ_READY(req_ready), .BUSY(busy), .RD_DATA(rd_data), .RD_VALID(rd_valid),
        .RD_READY(rd_ready), .IRQ_WORD(irq_word), .IRQ_FRAME(irq_frame), .SCLK(sclk),
        .CS_N(cs_n), .D_OUT(d_out), .D_OE_N(d_oe_n), .D_IN(d_in));
    qsr_flash_model u_qsr_flash_model (.clk(clk), .sclk(sclk), .cs_n(cs_n),
        .dummy(cfg.dummy), .d_in(d_in));

    // ------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk_word(input string nm, input logic [127:0] e, input logic [127:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_cnt(input string nm, input int e, input int g);
        n_tests++;
        if (g != e) begin
            fails++;
            $display("wrong value %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // ------------------------------------------------------------
    // One framed read, watched cycle by cycle at the falling edge
    // ------------------------------------------------------------
    task automatic run_read(input logic [1:0] pins, input logic [1:0] wid, input logic [7:0] div,
        input logic [1:0] dly, input logic [3:0] dum, input logic [6:0] len, input int words,
        input int stall);
        int t, p, ln, s, nf, f1, fl, cr, hi, bad, nw, nwi, nfr;
        logic [127:0] ew;
        logic [31:0] cmd;
        logic [3:0] sl;
        p = (div == 8'h00) ? 2 : int'(div) + 1;
        ln = (pins != PINS_6) ? 1 : (wid == WID_QUAD) ? 4 : (wid == WID_DUAL) ? 2 : 1;
        s = (int'(len) + ln) / ln;
        cfg = '{div: div, cs_dly: dly, word_len: len, word_cnt: 12'(words - 1), pins: pins,
            opcode: 8'h6b, dummy: dum, word_irq_en: 1'b1, frame_irq_en: 1'b1};
        req = '{addr: 24'h5a3c81, width: wid};
        req_valid = 1'b1;
        t = 0;
        while (cs_n !== 1'b0) begin
            @(negedge clk);
            t++;
            if (t > 20) begin
                fails++;
                complete_run();
            end
        end
        req_valid = 1'b0;
        {t, nf, f1, fl, cr, hi, bad, nw, nwi, nfr} = '0;
        cmd = '0;
        while (!(cs_n === 1'b1 && nw == words)) begin
            @(negedge clk);
            t++;
            rd_ready = (t >= stall);
            if (t > 20000) begin
                fails++;
                complete_run();
            end
            if (sclk === 1'b1 && hi == 0 && nf < 32) cmd = {cmd[30:0], d_out[0]};
            if (cs_n === 1'b1 && sclk !== 1'b0) bad++;
            if (sclk === 1'b1) begin
                hi++;
            end else if (hi > 0) begin
                nf++;
                if (nf == 1) f1 = t;
                fl = t;
                if (hi != p / 2) bad++;
                hi = 0;
            end
            // Enables drop in the cycle of the 32nd fall, so judge after counting it
            if (cs_n === 1'b0 && nf < 32 && d_oe_n !== OE_N_CMD) bad++;
            if (cs_n === 1'b1 && cr == 0) cr = t;
            nwi += int'(irq_word === 1'b1);
            nfr += int'(irq_frame === 1'b1);
            if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
                ew = '0;
                for (int j = 0; j < s; j++) begin
                    sl = 4'((nw * s + j) * 7 + 3);
                    ew = (ln == 4) ? {ew[123:0], sl} : (ln == 2) ? {ew[125:0], sl[1:0]}
                        : {ew[126:0], (pins == PINS_3) ? sl[0] : sl[1]};
                end
                ew = ew & ((128'h1 << (int'(len) + 1)) - 128'h1);
                chk_word("read word", ew, rd_data);
                nw++;
            end
        end
        rd_ready = 1'b0;
        chk_word("command bits", {96'h0, 8'h6b, 24'h5a3c81}, {96'h0, cmd});
        chk_cnt("first fall", (int'(dly) + 1) * p, f1);
        chk_cnt("select release", 2 * p, cr - fl);
        chk_cnt("fall count", 32 + int'(dum) + words * s, nf);
        chk_cnt("pin faults", 0, bad);
        chk_cnt("word events", words, nwi);
        chk_cnt("frame events", 1, nfr);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_idle();
        chk_word("idle pins", 128'({4'hc, 4'hf, 2'h0}),
            128'({cs_n, req_ready, busy, sclk, d_oe_n, irq_word, irq_frame}));
    endtask

    task automatic t_single3();
        run_read(PINS_3, WID_SINGLE, 8'h01, 2'h0, 4'h0, 7'h07, 1, 0);
    endtask

    task automatic t_quad_long();
        run_read(PINS_6, WID_QUAD, 8'h02, 2'h3, 4'h2, 7'h7f, 2, 0);
    endtask

    // Wide request on four wires falls back to one lane
    task automatic t_single4();
        run_read(PINS_4, WID_QUAD, 8'h00, 2'h2, 4'h1, 7'h00, 3, 0);
    endtask

    // Consumer stalls long enough for the buffer to refuse more
    task automatic t_dual_stall();
        run_read(PINS_6, WID_DUAL, 8'h03, 2'h1, 4'h0, 7'h02, 5, 400);
    endtask

    initial begin
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        t_idle();
        t_single3();
        t_quad_long();
        t_single4();
        t_dual_stall();
        t_idle();
        complete_run();
    end
endmodule
`default_nettype wire
